// ### inc/cpl_pkg.sv
// Shared constants and types for the cache partition-label block.
// Assumes one clock domain and same-clock request and config logic.
package cpl_pkg;
  // ----------------------------------------
  // Default widths and sizes
  // ----------------------------------------
  localparam int PID_W = 4;
  localparam int PMG_W = 2;
  localparam int TAG_W = 12;
  localparam int ENTRIES = 8;
  localparam int PORTIONS = 4;
  localparam int MON_CNT_W = 16;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RST_BITMAP_BIT = 1'b1;
  localparam logic [1:0] RST_SYNC = 2'h0;
  // ----------------------------------------
  // Request operations
  // ----------------------------------------
  typedef enum logic [1:0] {
    CPL_OP_READ = 2'h0,
    CPL_OP_WRITE = 2'h1,
    CPL_OP_CLEAN = 2'h2
  } cpl_op_t;
endpackage

// ### inc/cpl_set_if.sv
// Lookup path between the label cache and its settings table.
// Assumes the lookup is combinational within one cycle.
interface cpl_set_if #(
  parameter int IW = 5,
  parameter int PORTIONS = 4,
  parameter int CNT_W = 4
);
  logic [IW-1:0] idx;
  logic [PORTIONS-1:0] bitmap;
  logic [CNT_W-1:0] maxcap;
  modport table_mp(input idx, output bitmap, output maxcap);
  modport user_mp(output idx, input bitmap, input maxcap);
endinterface

// ### rtl/cpl_label_cache.sv
// Partition-label store and allocation control of a fully associative cache.
// Assumes request, config and monitor inputs come from logic on clk_in.
//
// Function
// - Allocated line keeps requester's partition, monitor group and space bit.
// - Miss fill read carries labels of the incoming request.
// - Non-last-level evict and clean carry the line's stored labels.
// - Eviction into another cache sends the original allocating labels.
// - Last level chooses request or stored labels for evictions.
// - Partition and space bit index a settings table per control.
// - Regulator compares setting with measured partition usage before allocating.
// - Portion bitmap limits allocation without any measurement.
// - Request labels select settings and drive usage accounting.
// - Monitor events filtered by stored labels, counted only for evictions and cleans sent downstream.
// - Storage monitor reports lines held by the chosen partition.
// - Portion and capacity controls both gate allocation.
// - A portion is a group of entries here.
// - Write hit may rewrite stored labels with request labels.
// - Label rewrite keeps the line in place by default.
// - Optional relocation when new bitmap lacks the line's portion.
module cpl_label_cache #(
  parameter int PID_W = cpl_pkg::PID_W,
  parameter int PMG_W = cpl_pkg::PMG_W,
  parameter int TAG_W = cpl_pkg::TAG_W,
  parameter int ENTRIES = cpl_pkg::ENTRIES,
  parameter int PORTIONS = cpl_pkg::PORTIONS
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire cpl_pkg::cpl_op_t req_op_in,
  input wire logic [TAG_W-1:0] req_tag_in,
  input wire logic [PID_W-1:0] req_pid_in,
  input wire logic [PMG_W-1:0] req_pmg_in,
  input wire logic req_ns_in,
  input wire logic cfg_last_level_in,
  input wire logic cfg_evict_req_labels_in,
  input wire logic cfg_update_on_write_in,
  input wire logic cfg_relocate_in,
  input wire logic set_wr_en_in,
  input wire logic [PID_W:0] set_wr_idx_in,
  input wire logic [PORTIONS-1:0] set_wr_bitmap_in,
  input wire logic [$clog2(ENTRIES+1)-1:0] set_wr_maxcap_in,
  input wire logic [PID_W-1:0] mon_pid_in,
  input wire logic [PMG_W-1:0] mon_pmg_in,
  input wire logic mon_ns_in,
  output logic rsp_valid_out,
  output logic rsp_hit_out,
  output logic rsp_alloc_out,
  output logic dn_fill_valid_out,
  output logic [TAG_W-1:0] dn_fill_tag_out,
  output logic [PID_W-1:0] dn_fill_pid_out,
  output logic [PMG_W-1:0] dn_fill_pmg_out,
  output logic dn_fill_ns_out,
  output logic dn_wb_valid_out,
  output logic dn_wb_clean_out,
  output logic [TAG_W-1:0] dn_wb_tag_out,
  output logic [PID_W-1:0] dn_wb_pid_out,
  output logic [PMG_W-1:0] dn_wb_pmg_out,
  output logic dn_wb_ns_out,
  output logic [$clog2(ENTRIES+1)-1:0] mon_storage_out,
  output logic [cpl_pkg::MON_CNT_W-1:0] mon_evict_cnt_out
);
  localparam int IW = PID_W + 1;
  localparam int NSET = 2 ** IW;
  localparam int EW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
  localparam int CNT_W = $clog2(ENTRIES + 1);
  localparam int EPP = ENTRIES / PORTIONS;
  localparam int MW = cpl_pkg::MON_CNT_W;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // Round-robin pointer wraps by width, so entries must be a power of two
  if (ENTRIES < 2 || (ENTRIES & (ENTRIES - 1)) != 0 || PORTIONS < 1 || ENTRIES % PORTIONS != 0) begin : g_bad
    $error("cpl_label_cache: bad ENTRIES or PORTIONS");
  end

  // ----------------------------------------
  // Types and state
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [TAG_W-1:0] tag;
    logic ns;
    logic [PID_W-1:0] pid;
    logic [PMG_W-1:0] monitor_group;
  } cpl_ent_t;

  typedef struct packed {
    cpl_ent_t [ENTRIES-1:0] ent;
    logic [NSET-1:0][CNT_W-1:0] use_cnt;
    logic [EW-1:0] rr;
    logic rsp_valid;
    logic rsp_hit;
    logic rsp_alloc;
    cpl_ent_t fill;
    cpl_ent_t wb;
    logic wb_clean;
    logic [CNT_W-1:0] mon_storage;
    logic [MW-1:0] mon_evict_cnt;
  } cpl_st_t;

  function automatic logic [IW-1:0] lab_idx(input logic ns, input logic [PID_W-1:0] pid);
    return {ns, pid};
  endfunction

  function automatic int portion_of(input int e);
    return e / EPP;
  endfunction

  logic [1:0] rs_ff;
  logic rst_n;
  cpl_st_t st_ff;
  cpl_st_t nxt_st;
  logic [IW-1:0] sidx;
  logic [ENTRIES-1:0] perm;
  logic hit;
  logic [EW-1:0] hit_idx;
  logic free_ok;
  logic [EW-1:0] free_idx;
  logic rr_ok;
  logic [EW-1:0] rr_idx;
  logic [EW-1:0] vic_idx;
  logic cap_ok;
  logic is_rw;
  logic miss_alloc;
  logic lab_upd;
  logic relocate;
  cpl_ent_t vic;
  cpl_ent_t hit_ent;
  cpl_ent_t req_ent;
  cpl_ent_t wb_src;
  logic wb_go;
  logic mon_hit;
  logic inc_en;
  logic dec_en;
  logic [IW-1:0] dec_idx;

  cpl_set_if #(.IW(IW), .PORTIONS(PORTIONS), .CNT_W(CNT_W)) set_lk ();

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rs_ff <= cpl_pkg::RST_SYNC;
    end else begin
      rs_ff <= {rs_ff[0], 1'b1};
    end
  end
  assign rst_n = rs_ff[1];

  cpl_settings_table #(.IW(IW), .PORTIONS(PORTIONS), .CNT_W(CNT_W), .ENTRIES(ENTRIES)) u_set (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .wr_en_in(set_wr_en_in),
    .wr_idx_in(set_wr_idx_in),
    .wr_bitmap_in(set_wr_bitmap_in),
    .wr_maxcap_in(set_wr_maxcap_in),
    .lk(set_lk)
  );

  // ----------------------------------------
  // Lookup and victim choice
  // ----------------------------------------
  // Space bit is part of the index, so secure and non-secure ids never alias
  assign sidx = lab_idx(req_ns_in, req_pid_in);
  assign set_lk.idx = sidx;

  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    free_ok = 1'b0;
    free_idx = '0;
    rr_ok = 1'b0;
    rr_idx = '0;
    perm = '0;
    for (int e = 0; e < ENTRIES; e++) begin
      perm[e] = set_lk.bitmap[portion_of(e)];
      if (!hit && st_ff.ent[e].valid && st_ff.ent[e].tag == req_tag_in) begin
        hit = 1'b1;
        hit_idx = EW'(e);
      end
      if (!free_ok && perm[e] && !st_ff.ent[e].valid) begin
        free_ok = 1'b1;
        free_idx = EW'(e);
      end
    end
    for (int k = 0; k < ENTRIES; k++) begin
      if (!rr_ok && perm[st_ff.rr + EW'(k)]) begin
        rr_ok = 1'b1;
        rr_idx = st_ff.rr + EW'(k);
      end
    end
  end

  // Empty permitted entries first, then round robin over permitted ones
  assign vic_idx = free_ok ? free_idx : rr_idx;
  assign vic = st_ff.ent[vic_idx];
  assign hit_ent = st_ff.ent[hit_idx];
  assign req_ent = {1'b1, req_tag_in, req_ns_in, req_pid_in, req_pmg_in};
  assign cap_ok = st_ff.use_cnt[sidx] < set_lk.maxcap;
  assign is_rw = req_valid_in && (req_op_in == cpl_pkg::CPL_OP_READ || req_op_in == cpl_pkg::CPL_OP_WRITE);
  // Both portion and capacity must agree before a line is taken
  assign miss_alloc = is_rw && !hit && (free_ok || rr_ok) && cap_ok;
  assign lab_upd = req_valid_in && req_op_in == cpl_pkg::CPL_OP_WRITE && hit && cfg_update_on_write_in
                   && ({hit_ent.ns, hit_ent.pid, hit_ent.monitor_group} != {req_ns_in, req_pid_in, req_pmg_in});
  // Relocation only into an empty permitted entry; otherwise line stays put
  assign relocate = lab_upd && cfg_relocate_in && !perm[hit_idx] && free_ok;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp_valid = req_valid_in;
    nxt_st.rsp_hit = req_valid_in && hit;
    nxt_st.rsp_alloc = miss_alloc;
    nxt_st.fill = '0;
    nxt_st.wb = '0;
    nxt_st.wb_clean = 1'b0;
    wb_go = 1'b0;
    wb_src = vic;
    inc_en = 1'b0;
    dec_en = 1'b0;
    dec_idx = '0;
    case (req_op_in)
      cpl_pkg::CPL_OP_READ, cpl_pkg::CPL_OP_WRITE: begin
        if (is_rw && !hit) begin
          nxt_st.fill = req_ent;
          if (miss_alloc) begin
            nxt_st.ent[vic_idx] = req_ent;
            inc_en = 1'b1;
            if (!free_ok) begin
              nxt_st.rr = vic_idx + EW'(1);
            end
            if (vic.valid) begin
              wb_go = 1'b1;
              dec_en = 1'b1;
              dec_idx = lab_idx(vic.ns, vic.pid);
            end
          end
        end
      end
      cpl_pkg::CPL_OP_CLEAN: begin
        if (req_valid_in && hit) begin
          wb_go = 1'b1;
          wb_src = hit_ent;
          nxt_st.wb_clean = 1'b1;
        end
      end
      default: begin
      end
    endcase
    if (lab_upd) begin
      inc_en = 1'b1;
      dec_en = 1'b1;
      dec_idx = lab_idx(hit_ent.ns, hit_ent.pid);
      nxt_st.ent[hit_idx] = {1'b1, hit_ent.tag, req_ns_in, req_pid_in, req_pmg_in};
      if (relocate) begin
        nxt_st.ent[hit_idx].valid = 1'b0;
        nxt_st.ent[free_idx] = {1'b1, hit_ent.tag, req_ns_in, req_pid_in, req_pmg_in};
      end
    end
    if (wb_go) begin
      nxt_st.wb = wb_src;
      nxt_st.wb.valid = 1'b1;
      if (cfg_last_level_in && cfg_evict_req_labels_in) begin
        nxt_st.wb.ns = req_ns_in;
        nxt_st.wb.pid = req_pid_in;
        nxt_st.wb.monitor_group = req_pmg_in;
      end
    end
    // Filter always uses the stored labels, never the override
    mon_hit = wb_go && {wb_src.ns, wb_src.pid, wb_src.monitor_group} == {mon_ns_in, mon_pid_in, mon_pmg_in};
    if (mon_hit) begin
      nxt_st.mon_evict_cnt = st_ff.mon_evict_cnt + MW'(1);
    end
    for (int i = 0; i < NSET; i++) begin
      nxt_st.use_cnt[i] = st_ff.use_cnt[i] + CNT_W'(inc_en && sidx == IW'(i))
                          - CNT_W'(dec_en && dec_idx == IW'(i));
    end
    nxt_st.mon_storage = nxt_st.use_cnt[lab_idx(mon_ns_in, mon_pid_in)];
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rsp_valid_out = st_ff.rsp_valid;
  assign rsp_hit_out = st_ff.rsp_hit;
  assign rsp_alloc_out = st_ff.rsp_alloc;
  assign dn_fill_valid_out = st_ff.fill.valid;
  assign dn_fill_tag_out = st_ff.fill.tag;
  assign dn_fill_pid_out = st_ff.fill.pid;
  assign dn_fill_pmg_out = st_ff.fill.monitor_group;
  assign dn_fill_ns_out = st_ff.fill.ns;
  assign dn_wb_valid_out = st_ff.wb.valid;
  assign dn_wb_clean_out = st_ff.wb_clean;
  assign dn_wb_tag_out = st_ff.wb.tag;
  assign dn_wb_pid_out = st_ff.wb.pid;
  assign dn_wb_pmg_out = st_ff.wb.monitor_group;
  assign dn_wb_ns_out = st_ff.wb.ns;
  assign mon_storage_out = st_ff.mon_storage;
  assign mon_evict_cnt_out = st_ff.mon_evict_cnt;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [CNT_W-1:0] ref_cnt;
  always_comb begin
    ref_cnt = '0;
    for (int e = 0; e < ENTRIES; e++) begin
      ref_cnt = ref_cnt + CNT_W'(st_ff.ent[e].valid && {st_ff.ent[e].ns, st_ff.ent[e].pid} == {mon_ns_in, mon_pid_in});
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  alloc_keep_a: assert property (miss_alloc |=> st_ff.ent[$past(vic_idx)] == $past(req_ent))
    else $error("allocated line lost its labels");
  fill_label_a: assert property ((is_rw && !hit) |=> dn_fill_valid_out && dn_fill_pid_out == $past(req_pid_in)
    && dn_fill_pmg_out == $past(req_pmg_in) && dn_fill_ns_out == $past(req_ns_in))
    else $error("fill labels differ from request");
  clean_label_a: assert property ((req_valid_in && req_op_in == cpl_pkg::CPL_OP_CLEAN && hit && !cfg_last_level_in)
    |=> dn_wb_valid_out && dn_wb_clean_out && dn_wb_pid_out == $past(hit_ent.pid))
    else $error("clean labels differ from stored");
  evict_label_a: assert property ((miss_alloc && vic.valid && !cfg_last_level_in) |=> dn_wb_valid_out
    && !dn_wb_clean_out && dn_wb_pid_out == $past(vic.pid) && dn_wb_pmg_out == $past(vic.monitor_group))
    else $error("evict labels differ from stored");
  llc_req_a: assert property ((miss_alloc && vic.valid && cfg_last_level_in && cfg_evict_req_labels_in)
    |=> dn_wb_pid_out == $past(req_pid_in) && dn_wb_ns_out == $past(req_ns_in))
    else $error("last level evict not request labelled");
  portion_ok_a: assert property (miss_alloc |-> perm[vic_idx])
    else $error("allocation outside permitted portion");
  cap_deny_a: assert property ((is_rw && !hit && !cap_ok) |=> rsp_valid_out && !rsp_alloc_out)
    else $error("allocation beyond capacity");
  storage_mon_a: assert property (($stable(mon_pid_in) && $stable(mon_ns_in)) |-> mon_storage_out == ref_cnt)
    else $error("storage monitor miscounts");
  wr_stay_a: assert property ((lab_upd && !relocate) |=> st_ff.ent[$past(hit_idx)].valid
    && st_ff.ent[$past(hit_idx)].pid == $past(req_pid_in))
    else $error("label update moved or lost line");
  reloc_a: assert property (relocate |=> !st_ff.ent[$past(hit_idx)].valid
    && st_ff.ent[$past(free_idx)].pid == $past(req_pid_in))
    else $error("relocation failed");
  mon_evt_a: assert property (mon_hit |=> mon_evict_cnt_out == $past(mon_evict_cnt_out) + MW'(1))
    else $error("monitor event not counted");

  evict_c: cover property (miss_alloc && vic.valid);
  upd_c: cover property (lab_upd && !relocate);
  reloc_c: cover property (relocate);
  clean_c: cover property (req_valid_in && req_op_in == cpl_pkg::CPL_OP_CLEAN && hit);
endmodule

// ### rtl/cpl_settings_table.sv
// Per-partition settings: portion bitmap and maximum line count.
// Assumes writes come from same-clock configuration logic.
module cpl_settings_table #(
  parameter int IW = 5,
  parameter int PORTIONS = 4,
  parameter int CNT_W = 4,
  parameter int ENTRIES = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [IW-1:0] wr_idx_in,
  input wire logic [PORTIONS-1:0] wr_bitmap_in,
  input wire logic [CNT_W-1:0] wr_maxcap_in,
  cpl_set_if.table_mp lk
);
  localparam int NSET = 2 ** IW;

  typedef struct packed {
    logic [PORTIONS-1:0] bitmap;
    logic [CNT_W-1:0] maxcap;
  } cpl_set_t;

  typedef struct packed {
    cpl_set_t [NSET-1:0] tab;
  } cpl_tab_st_t;

  cpl_tab_st_t st_ff;
  cpl_tab_st_t nxt_st;

  // ----------------------------------------
  // Lookup, one table per control pair
  // ----------------------------------------
  assign lk.bitmap = st_ff.tab[lk.idx].bitmap;
  assign lk.maxcap = st_ff.tab[lk.idx].maxcap;

  always_comb begin
    nxt_st = st_ff;
    if (wr_en_in) begin
      nxt_st.tab[wr_idx_in].bitmap = wr_bitmap_in;
      nxt_st.tab[wr_idx_in].maxcap = wr_maxcap_in;
    end
  end

  // Reset grants every portion and full capacity
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NSET; i++) begin
        st_ff.tab[i].bitmap <= {PORTIONS{cpl_pkg::RST_BITMAP_BIT}};
        st_ff.tab[i].maxcap <= CNT_W'(ENTRIES);
      end
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ### tb/cpl_down_model.sv
// Downstream sink model: takes every fill read and write-back at once.
// Assumes the cache's request pulses are registered on clk_in.
module cpl_down_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic fill_valid_in,
  input wire logic wb_valid_in,
  input wire logic wb_clean_in,
  output logic [15:0] fill_cnt_out,
  output logic [15:0] clean_cnt_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Request counters
  // ----------------------------------------
  // No stall port on the cache side, so the sink never pushes back
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fill_cnt_out <= 16'h0000;
      clean_cnt_out <= 16'h0000;
    end else begin
      if (fill_valid_in) begin
        fill_cnt_out <= fill_cnt_out + 16'h0001;
      end
      if (wb_valid_in && wb_clean_in) begin
        clean_cnt_out <= clean_cnt_out + 16'h0001;
      end
    end
  end
endmodule

// ### tb/tb_cache_partition_label_logic.sv
// Self-checking bench for the partition-label cache.
// Assumes default package widths: 8 entries, 4 portions, 4-bit partition.
module tb_cache_partition_label_logic;
  timeunit 1ns;
  timeprecision 1ns;
  localparam cpl_pkg::cpl_op_t RD = cpl_pkg::CPL_OP_READ;
  localparam cpl_pkg::cpl_op_t WR = cpl_pkg::CPL_OP_WRITE;
  localparam cpl_pkg::cpl_op_t CL = cpl_pkg::CPL_OP_CLEAN;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic req_valid = 1'b0;
  cpl_pkg::cpl_op_t req_op = cpl_pkg::CPL_OP_READ;
  logic [11:0] req_tag = 12'h000;
  logic [3:0] req_pid = 4'h0;
  logic [1:0] req_pmg = 2'h0;
  logic req_ns = 1'b0;
  logic last_lvl = 1'b0;
  logic ev_req = 1'b0;
  logic upd_wr = 1'b0;
  logic reloc = 1'b0;
  logic set_en = 1'b0;
  logic [4:0] set_idx = 5'h00;
  logic [3:0] set_bm = 4'h0;
  logic [3:0] set_cap = 4'h0;
  logic [3:0] mon_pid = 4'h0;
  logic [1:0] mon_pmg = 2'h0;
  logic mon_ns = 1'b0;
  logic rsp_v, rsp_hit, rsp_alloc, fill_v, fill_ns, wb_v, wb_clean, wb_ns;
  logic [11:0] fill_tag, wb_tag;
  logic [3:0] fill_pid, wb_pid, storage;
  logic [1:0] fill_pmg, wb_pmg;
  logic [15:0] ev_cnt, fill_cnt, clean_cnt;
  int n_errors = 0;
  int checked = 0;

  cpl_label_cache dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid), .req_op_in(req_op),
    .req_tag_in(req_tag), .req_pid_in(req_pid), .req_pmg_in(req_pmg), .req_ns_in(req_ns),
    .cfg_last_level_in(last_lvl), .cfg_evict_req_labels_in(ev_req), .cfg_update_on_write_in(upd_wr),
    .cfg_relocate_in(reloc), .set_wr_en_in(set_en), .set_wr_idx_in(set_idx), .set_wr_bitmap_in(set_bm),
    .set_wr_maxcap_in(set_cap), .mon_pid_in(mon_pid), .mon_pmg_in(mon_pmg), .mon_ns_in(mon_ns),
    .rsp_valid_out(rsp_v), .rsp_hit_out(rsp_hit), .rsp_alloc_out(rsp_alloc), .dn_fill_valid_out(fill_v),
    .dn_fill_tag_out(fill_tag), .dn_fill_pid_out(fill_pid), .dn_fill_pmg_out(fill_pmg), .dn_fill_ns_out(fill_ns),
    .dn_wb_valid_out(wb_v), .dn_wb_clean_out(wb_clean), .dn_wb_tag_out(wb_tag), .dn_wb_pid_out(wb_pid),
    .dn_wb_pmg_out(wb_pmg), .dn_wb_ns_out(wb_ns), .mon_storage_out(storage), .mon_evict_cnt_out(ev_cnt));

  cpl_down_model down (.clk_in(clk_in), .rst_n_in(rst_n_in), .fill_valid_in(fill_v), .wb_valid_in(wb_v),
    .wb_clean_in(wb_clean), .fill_cnt_out(fill_cnt), .clean_cnt_out(clean_cnt));

  always #25 clk_in = ~clk_in;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Labels tied to the tag, so a victim's expected labels follow from its tag
  function automatic logic [6:0] lab(input logic [11:0] t);
    return {t[3:0], t[5:4], t[6]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("Checks made: %0d, mismatches: %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    {last_lvl, ev_req, upd_wr, reloc} <= 4'h0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    // Look at outputs away from the edge that launches them
    @(negedge clk_in);
  endtask

  task automatic cfg(input logic [3:0] c);
    @(posedge clk_in);
    {last_lvl, ev_req, upd_wr, reloc} <= c;
  endtask

  // Every request carries all three labels
  task automatic req(input cpl_pkg::cpl_op_t op, input logic [11:0] t, input logic [3:0] pid,
      input logic [1:0] monitor_group, input logic ns);
    @(posedge clk_in);
    req_valid <= 1'b1;
    // Enum target takes its own assignment, not a slice of a concatenation
    req_op <= op;
    req_tag <= t;
    req_pid <= pid;
    req_pmg <= monitor_group;
    req_ns <= ns;
    @(posedge clk_in);
    req_valid <= 1'b0;
    @(negedge clk_in);
  endtask

  task automatic reqf(input cpl_pkg::cpl_op_t op, input logic [11:0] t);
    req(op, t, t[3:0], t[5:4], t[6]);
  endtask

  task automatic set_wr(input logic [4:0] idx, input logic [3:0] bm, input logic [3:0] cap);
    @(posedge clk_in);
    set_en <= 1'b1;
    {set_idx, set_bm, set_cap} <= {idx, bm, cap};
    @(posedge clk_in);
    set_en <= 1'b0;
  endtask

  // Storage monitor is registered one cycle behind its inputs; wait two edges
  task automatic mon_chk(input logic ns, input logic [3:0] pid, input logic [3:0] exp);
    @(posedge clk_in);
    {mon_ns, mon_pid} <= {ns, pid};
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk(storage, exp);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_fill();
    do_reset();
    chk({rsp_v, fill_v, wb_v, storage}, 7'h00);
    reqf(RD, 12'h0c3);
    chk({rsp_v, rsp_hit, rsp_alloc, wb_v}, 4'ha);
    chk({fill_v, fill_tag, fill_pid, fill_pmg, fill_ns}, {1'b1, 12'h0c3, lab(12'h0c3)});
    reqf(RD, 12'h0c3);
    chk({rsp_hit, fill_v}, 2'h2);
    mon_chk(1'b1, 4'h3, 4'h1);
  endtask

  task automatic t_evict();
    do_reset();
    for (int i = 0; i < 8; i++) begin
      reqf(WR, 12'h010 + 12'(i));
    end
    reqf(RD, 12'h0a8);
    chk({wb_v, wb_clean, wb_tag[11:3]}, {2'h2, 9'h002});
    chk({wb_pid, wb_pmg, wb_ns}, lab(12'h010));
    cfg(4'hc);
    reqf(RD, 12'h0b9);
    chk({wb_v, wb_pid, wb_pmg, wb_ns}, {1'b1, lab(12'h0b9)});
    cfg(4'h8);
    reqf(RD, 12'h0ca);
    chk({wb_v, wb_tag, wb_pid, wb_pmg, wb_ns}, {1'b1, 12'h012, lab(12'h012)});
  endtask

  task automatic t_clean();
    do_reset();
    reqf(RD, 12'h001);
    mon_chk(1'b0, 4'h1, 4'h1);
    req(CL, 12'h001, 4'he, 2'h3, 1'b1);
    chk({rsp_hit, wb_v, wb_clean, wb_tag}, {3'h7, 12'h001});
    chk({wb_pid, wb_pmg, wb_ns}, lab(12'h001));
    cfg(4'hc);
    req(CL, 12'h001, 4'he, 2'h3, 1'b1);
    chk({wb_pid, wb_pmg, wb_ns}, {4'he, 2'h3, 1'b1});
    req(CL, 12'h055, 4'h0, 2'h0, 1'b0);
    chk({rsp_v, wb_v, fill_v}, 3'h4);
    @(negedge clk_in);
    chk({ev_cnt, clean_cnt}, {16'h0002, 16'h0002});
  endtask

  task automatic t_portion();
    do_reset();
    set_wr(5'h12, 4'h4, 4'h8);
    req(RD, 12'h101, 4'h2, 2'h0, 1'b1);
    req(RD, 12'h102, 4'h2, 2'h0, 1'b1);
    chk({rsp_alloc, wb_v}, 2'h2);
    req(RD, 12'h103, 4'h2, 2'h0, 1'b1);
    chk({rsp_alloc, wb_v, wb_tag}, {2'h3, 12'h101});
    chk({wb_pid, wb_pmg, wb_ns}, {4'h2, 2'h0, 1'b1});
  endtask

  task automatic t_cap();
    do_reset();
    set_wr(5'h07, 4'hf, 4'h1);
    req(RD, 12'h201, 4'h7, 2'h0, 1'b0);
    chk(rsp_alloc, 1'b1);
    req(RD, 12'h202, 4'h7, 2'h0, 1'b0);
    chk({rsp_alloc, fill_v, wb_v}, 3'h2);
    set_wr(5'h07, 4'h1, 4'h8);
    req(RD, 12'h203, 4'h7, 2'h0, 1'b0);
    chk({rsp_alloc, wb_v}, 2'h2);
    req(RD, 12'h204, 4'h7, 2'h0, 1'b0);
    chk({rsp_alloc, wb_v}, 2'h3);
    mon_chk(1'b0, 4'h7, 4'h2);
  endtask

  task automatic t_update();
    do_reset();
    cfg(4'h2);
    req(RD, 12'h301, 4'h4, 2'h0, 1'b0);
    req(WR, 12'h301, 4'h6, 2'h3, 1'b0);
    chk({rsp_hit, fill_v}, 2'h2);
    mon_chk(1'b0, 4'h6, 4'h1);
    mon_chk(1'b0, 4'h4, 4'h0);
    set_wr(5'h09, 4'h2, 4'h8);
    req(WR, 12'h301, 4'h9, 2'h1, 1'b0);
    req(RD, 12'h301, 4'h9, 2'h1, 1'b0);
    chk(rsp_hit, 1'b1);
    req(CL, 12'h301, 4'h0, 2'h0, 1'b0);
    chk({wb_pid, wb_pmg, wb_ns}, {4'h9, 2'h1, 1'b0});
    cfg(4'h3);
    set_wr(5'h0a, 4'h2, 4'h8);
    req(WR, 12'h301, 4'ha, 2'h0, 1'b0);
    req(RD, 12'h301, 4'ha, 2'h0, 1'b0);
    chk(rsp_hit, 1'b1);
    mon_chk(1'b0, 4'ha, 4'h1);
    cfg(4'h0);
    req(WR, 12'h301, 4'hb, 2'h0, 1'b0);
    mon_chk(1'b0, 4'hb, 4'h0);
    chk(fill_cnt, 16'h0001);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    t_fill();
    t_evict();
    t_clean();
    t_portion();
    t_cap();
    t_update();
    finish_test();
  end

  // Bounds the whole run in case a task stalls
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    finish_test();
  end
endmodule
